// ==== design/mailbox_pkg.sv ====
// constants shared by the parameter mailbox and its register bus slave
// assumes: a 25 MHz system clock and 32-bit software registers
package mailbox_pkg;
   // request block fields
   localparam logic [3:0] REQ_TAG = 4'h4;
   localparam int CTRL_TOP_BIT = 7;
   localparam int CTRL_KIND_BIT = 6;
   localparam int ADDR_LO_W = 6;
   localparam int ADDR_HI_W = 4;
   localparam int ADDR_W = 10;
   // answer block fields
   localparam logic [1:0] ACK_TAG = 2'h1;
   localparam int ST_ERR_BIT = 5;
   localparam int ST_BUSY_BIT = 4;
   localparam int ST_KIND_BIT = 0;
   localparam logic [7:0] STATUS0_VALUE = 8'h00;
   // parameter numbers
   localparam logic [9:0] PARAM_CFG_ADDR = 10'h0A8;
   localparam logic [9:0] PARAM_DET_ADDR = 10'h0B0;
   // error codes returned with the error flag
   localparam logic [31:0] ERR_NO_PARAM = 32'h0000_0001;
   localparam logic [31:0] ERR_READ_ONLY = 32'h0000_0002;
   localparam logic [31:0] ERR_LOCKED = 32'h0000_0003;
   // software register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATE = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_CFG_MASK = 8'h10;
   localparam logic [7:0] OFS_DET_MASK = 8'h14;
   // control register bits
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LOCK_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // interrupt event bits and bus response codes
   localparam int IRQ_W = 3;
   localparam int IRQ_WR_DONE = 0;
   localparam int IRQ_RD_DONE = 1;
   localparam int IRQ_ERROR = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACK = 1'b1
   } mbox_state_e;
endpackage : mailbox_pkg

// ==== design/param_mailbox.sv ====
// parameter mailbox of a sensor-link master with an AXI4-Lite register slave
// assumes: the six request bytes are synchronous to clk_sys and the
// detected-node mask is supplied by the link logic
//
// Summary of operation
// R1: controller waits until status nibble reads zero
// R2: both control bytes zero clears status nibble
// R3: address bits 5..0 byte 0, 9..6 byte 1
// R4: write request tags 01 and 0100, value follows
// R5: read request tags 00 and 0100, value ignored
// R6: value bytes carried least significant first
// R7: write acknowledge is 01F1xxx1
// R8: write error sets flag, error code returned
// R9: read acknowledge is 01F1xxx0
// R10: read returns value, or flag and error code
// R11: controller ends access with both bytes zero
// R12: request value ignored while control bytes zero
// R13: parameter 0xA8 is writable configured-node mask
// R14: parameter 0xB0 reads detected-node mask
// R15: acknowledge held until control bytes clear
`timescale 1ns/1ns
module param_mailbox
   import mailbox_pkg::*;
#(
   parameter int NODES = 32,
   parameter logic [31:0] CFG_MASK_RESET = 32'h0000_0000
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // request block from the controller
   input wire logic [7:0] ctrl_byte0,
   input wire logic [7:0] ctrl_byte1,
   input wire logic [7:0] request_value_byte0,
   input wire logic [7:0] request_value_byte1,
   input wire logic [7:0] request_value_byte2,
   input wire logic [7:0] request_value_byte3,
   // answer block to the controller
   output logic [7:0] status_byte0,
   output logic [7:0] status_byte1,
   output logic [7:0] response_value_byte0,
   output logic [7:0] response_value_byte1,
   output logic [7:0] response_value_byte2,
   output logic [7:0] response_value_byte3,
   // link side
   input wire logic [NODES-1:0] detected_slave_mask,
   output logic [NODES-1:0] configured_slave_mask,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   output logic irq
);
   mbox_state_e state, next_state;
   logic [7:0] next_status1;
   logic [31:0] resp_word, next_resp_word;
   logic [NODES-1:0] next_cfg_mask;
   logic [ADDR_W-1:0] last_addr, next_last_addr;
   logic ctrl_zero, req_ok, accept, is_wr, acc_err;
   logic [ADDR_W-1:0] req_addr;
   logic [31:0] req_word, acc_code;
   logic [1:0] ctrl_reg, next_ctrl_reg;
   logic [IRQ_W-1:0] irq_mask, next_irq_mask, irq_flags, irq_set, irq_clr;
   logic wr_go, rd_go, next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   assign ctrl_zero = (ctrl_byte0 == 8'h00) && (ctrl_byte1 == 8'h00);
   // only the documented tags start an access; any other pattern is ignored
   assign req_ok = (ctrl_byte1[7:4] == REQ_TAG) && !ctrl_byte0[CTRL_TOP_BIT];
   assign accept = (state == ST_IDLE) && req_ok && ctrl_reg[CTRL_EN_BIT];
   assign is_wr = ctrl_byte0[CTRL_KIND_BIT]; // R4 R5
   assign req_addr = {ctrl_byte1[ADDR_HI_W-1:0],
                      ctrl_byte0[ADDR_LO_W-1:0]}; // R3
   assign req_word = {request_value_byte3, request_value_byte2,
                      request_value_byte1, request_value_byte0}; // R6

   // decode one access into an error flag and an answer word
   always_comb
   begin
      acc_err = 1'b0;
      acc_code = '0;
      if (is_wr)
      begin
         if (req_addr == PARAM_CFG_ADDR && !ctrl_reg[CTRL_LOCK_BIT])
            acc_code = '0; // R8
         else
         begin
            acc_err = 1'b1; // R8
            if (req_addr == PARAM_CFG_ADDR)
               acc_code = ERR_LOCKED;
            else if (req_addr == PARAM_DET_ADDR)
               acc_code = ERR_READ_ONLY;
            else
               acc_code = ERR_NO_PARAM;
         end
      end
      else if (req_addr == PARAM_CFG_ADDR)
         acc_code = 32'(configured_slave_mask); // R10
      else if (req_addr == PARAM_DET_ADDR)
         acc_code = 32'(detected_slave_mask); // R14
      else
      begin
         acc_err = 1'b1; // R10
         acc_code = ERR_NO_PARAM;
      end
   end

   always_comb
   begin
      next_state = state;
      next_status1 = status_byte1;
      next_resp_word = resp_word;
      next_cfg_mask = configured_slave_mask;
      next_last_addr = last_addr;
      case (state)
         ST_IDLE:
         begin
            // value bytes only read when a valid request is present
            if (accept) // R12
            begin
               next_state = ST_ACK;
               next_last_addr = req_addr;
               next_resp_word = acc_code; // R6
               next_status1 = '0;
               next_status1[7:6] = ACK_TAG; // R7 R9
               next_status1[ST_ERR_BIT] = acc_err;
               next_status1[ST_BUSY_BIT] = 1'b1;
               next_status1[ST_KIND_BIT] = is_wr; // R7 R9
               if (is_wr && !acc_err)
                  next_cfg_mask = req_word[NODES-1:0]; // R13
            end
         end
         ST_ACK:
         begin
            // answer stays frozen until the controller withdraws
            if (ctrl_zero) // R15
            begin
               next_state = ST_IDLE;
               next_status1 = '0; // R2
            end
         end
         default:
         begin
            next_state = ST_IDLE;
            next_status1 = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         status_byte1 <= '0;
         resp_word <= '0;
         configured_slave_mask <= CFG_MASK_RESET;
         last_addr <= '0;
      end
      else
      begin
         state <= next_state;
         status_byte1 <= next_status1;
         resp_word <= next_resp_word;
         configured_slave_mask <= next_cfg_mask;
         last_addr <= next_last_addr;
      end
   end

   assign status_byte0 = STATUS0_VALUE;
   assign response_value_byte0 = resp_word[7:0]; // R6
   assign response_value_byte1 = resp_word[15:8];
   assign response_value_byte2 = resp_word[23:16];
   assign response_value_byte3 = resp_word[31:24];

   // interrupt events
   always_comb
   begin
      irq_set = '0;
      irq_set[IRQ_WR_DONE] = accept && is_wr;
      irq_set[IRQ_RD_DONE] = accept && !is_wr;
      irq_set[IRQ_ERROR] = accept && acc_err;
   end

   assign irq_clr = (wr_go && s_axi_awaddr == OFS_IRQ_STATUS && s_axi_wstrb[0])
                    ? s_axi_wdata[IRQ_W-1:0] : '0;

   sticky_events #(.W(IRQ_W)) u_events (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .set_bits(irq_set),
      .clear_bits(irq_clr),
      .mask(irq_mask),
      .flags(irq_flags),
      .irq(irq)
   );

   // AXI4-Lite: address and data are taken together, one write at a time
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb
   begin
      next_ctrl_reg = ctrl_reg;
      next_irq_mask = irq_mask;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      if (wr_go)
      begin
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (s_axi_awaddr)
            OFS_CTRL:
               if (s_axi_wstrb[0])
                  next_ctrl_reg = s_axi_wdata[1:0];
            OFS_IRQ_MASK:
               if (s_axi_wstrb[0])
                  next_irq_mask = s_axi_wdata[IRQ_W-1:0];
            OFS_IRQ_STATUS, OFS_STATE, OFS_CFG_MASK, OFS_DET_MASK:
               next_bresp = RESP_OKAY;
            default:
               next_bresp = RESP_SLVERR;
         endcase
      end
   end

   always_comb
   begin
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (rd_go)
      begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL: next_rdata = {30'h0000_0000, ctrl_reg};
            OFS_STATE: next_rdata = {13'h0000, status_byte1,
                                     last_addr, state};
            OFS_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_flags};
            OFS_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
            OFS_CFG_MASK: next_rdata = 32'(configured_slave_mask);
            OFS_DET_MASK: next_rdata = 32'(detected_slave_mask);
            default:
            begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg <= CTRL_RESET;
         irq_mask <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         ctrl_reg <= next_ctrl_reg;
         irq_mask <= next_irq_mask;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // checks
   sequence s_write_req;
      accept && is_wr;
   endsequence

   sequence s_read_req;
      accept && !is_wr;
   endsequence

   chk_ready_clear: assert property ( // R2
      @(posedge clk_sys) disable iff (!arst_n)
      (state == ST_ACK && ctrl_zero)
      |=> (status_byte1[7:4] == 4'h0) && state == ST_IDLE)
      else $error("status nibble not cleared after zero control");

   chk_write_ack: assert property ( // R7
      @(posedge clk_sys) disable iff (!arst_n)
      s_write_req |=> status_byte1[7:6] == ACK_TAG
         && status_byte1[ST_BUSY_BIT] && status_byte1[ST_KIND_BIT])
      else $error("bad write acknowledge");

   chk_read_ack: assert property ( // R9
      @(posedge clk_sys) disable iff (!arst_n)
      s_read_req |=> status_byte1[7:6] == ACK_TAG
         && status_byte1[ST_BUSY_BIT] && !status_byte1[ST_KIND_BIT])
      else $error("bad read acknowledge");

   chk_write_error: assert property ( // R8
      @(posedge clk_sys) disable iff (!arst_n)
      s_write_req ##1 status_byte1[ST_ERR_BIT]
      |-> resp_word != 32'h0000_0000)
      else $error("write error without code");

   chk_cfg_update: assert property ( // R13
      @(posedge clk_sys) disable iff (!arst_n)
      s_write_req ##0 (req_addr == PARAM_CFG_ADDR && !ctrl_reg[CTRL_LOCK_BIT])
      |=> configured_slave_mask == $past(req_word[NODES-1:0])
         && !status_byte1[ST_ERR_BIT])
      else $error("configured mask not written");

   chk_det_read: assert property ( // R14
      @(posedge clk_sys) disable iff (!arst_n)
      s_read_req ##0 (req_addr == PARAM_DET_ADDR)
      |=> {response_value_byte3, response_value_byte2, response_value_byte1,
           response_value_byte0} == 32'($past(detected_slave_mask))
         && !status_byte1[ST_ERR_BIT])
      else $error("detected mask read wrong");

   chk_ack_hold: assert property ( // R15
      @(posedge clk_sys) disable iff (!arst_n)
      (state == ST_ACK && !ctrl_zero) |=> $stable(status_byte1)
         && $stable(resp_word) && $stable(configured_slave_mask))
      else $error("acknowledge changed while held");

   chk_idle_quiet: assert property ( // R12
      @(posedge clk_sys) disable iff (!arst_n)
      (state == ST_IDLE && ctrl_zero)[*2] |-> status_byte1 == 8'h00
         && $stable(resp_word))
      else $error("idle block reacted to zero control");

   chk_addr_split: assert property ( // R3
      @(posedge clk_sys) disable iff (!arst_n)
      accept |=> last_addr == {$past(ctrl_byte1[3:0]), $past(ctrl_byte0[5:0])})
      else $error("address assembled wrongly");

   chk_irq_event: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      s_write_req ##0 irq_mask[IRQ_WR_DONE] |=> irq)
      else $error("write event raised no interrupt");
endmodule : param_mailbox

// ==== design/sticky_events.sv ====
// sticky event flags with write-one-to-clear and a masked level interrupt
// assumes: set and clear vectors are synchronous one-cycle strobes
`timescale 1ns/1ns
module sticky_events
#(
   parameter int W = 3
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // events and software access
   input wire logic [W-1:0] set_bits,
   input wire logic [W-1:0] clear_bits,
   input wire logic [W-1:0] mask,
   // results
   output logic [W-1:0] flags,
   output logic irq
);
   logic [W-1:0] next_flags;

   // a set in the clearing cycle wins so no event is lost
   always_comb
   begin
      next_flags = (flags & ~clear_bits) | set_bits;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         flags <= '0;
      else
         flags <= next_flags;
   end

   assign irq = |(flags & mask);
endmodule : sticky_events

// ==== testbench/link_ctrl_model.sv ====
// controller model: presents the request block, waits, then clears it
// assumes: the bench issues one access at a time through go
`timescale 1ns/1ns
module link_ctrl_model
   import mailbox_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // command from the bench
   input wire logic go,
   input wire logic wr,
   input wire logic bad_tag,
   input wire logic [9:0] addr,
   input wire logic [31:0] value,
   input wire logic [3:0] stall,
   // block exchange
   input wire logic [7:0] status_byte1,
   input wire logic [31:0] rsp,
   output logic [7:0] ctrl_byte0,
   output logic [7:0] ctrl_byte1,
   output logic [31:0] req,
   // what was seen
   output logic done,
   output logic [7:0] ack_st,
   output logic [31:0] ack_val,
   output logic [7:0] late_st,
   output logic [31:0] late_val
);
   logic [1:0] st;
   logic [3:0] cnt;
   logic keep;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= 2'h0;
         cnt <= 4'h0;
         keep <= 1'b0;
         done <= 1'b0;
         ctrl_byte0 <= 8'h00;
         ctrl_byte1 <= 8'h00;
         req <= 32'h5A5A_A5A5;
      end
      else
      begin
         done <= 1'b0;
         // value lines carry no meaning unless a write is up: keep them moving
         if (!keep)
            req <= ~req;
         case (st)
            2'h0:
               if (go && status_byte1[7:4] == 4'h0)
               begin
                  ctrl_byte0 <= {1'b0, wr, addr[5:0]};
                  ctrl_byte1 <= {bad_tag ? 4'h5 : REQ_TAG, addr[9:6]};
                  keep <= wr;
                  if (wr)
                     req <= value;
                  st <= 2'h1;
               end
            2'h1:
            begin
               if (!bad_tag)
                  ctrl_byte1[7:4] <= REQ_TAG;
               if (status_byte1[4])
               begin
                  ack_st <= status_byte1;
                  ack_val <= rsp;
                  cnt <= stall;
                  st <= 2'h2;
               end
            end
            2'h2:
               if (cnt == 4'h0)
               begin
                  late_st <= status_byte1;
                  late_val <= rsp;
                  ctrl_byte0 <= 8'h00;
                  ctrl_byte1 <= 8'h00;
                  keep <= 1'b0;
                  st <= 2'h3;
               end
               else
                  cnt <= cnt - 4'h1;
            default:
               if (status_byte1[7:4] == 4'h0)
               begin
                  done <= 1'b1;
                  st <= 2'h0;
               end
         endcase
      end
   end
endmodule : link_ctrl_model

// ==== testbench/param_mailbox_tb.sv ====
// self-checking bench of the parameter mailbox and its register slave
// assumes: the controller model stands on the request block side
`timescale 1ns/1ns
module param_mailbox_tb
   import mailbox_pkg::*;
;
   logic clk_sys, arst_n, go, go_w, bad_tag, done, irq, e_err, m_lock;
   logic [9:0] go_a, ra;
   logic [3:0] go_s;
   logic [31:0] go_v, req, det, cfg, ack_val, late_val, e_val, m_cfg, q;
   logic [7:0] c0, c1, s0, s1, r0, r1, r2, r3, ack_st, late_st, e_st;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int n_mismatch, num_checks, k;

   param_mailbox i_param_mailbox (.clk_sys(clk_sys), .arst_n(arst_n),
      .ctrl_byte0(c0), .ctrl_byte1(c1), .request_value_byte0(req[7:0]),
      .request_value_byte1(req[15:8]), .request_value_byte2(req[23:16]),
      .request_value_byte3(req[31:24]), .status_byte0(s0),
      .status_byte1(s1), .response_value_byte0(r0),
      .response_value_byte1(r1), .response_value_byte2(r2),
      .response_value_byte3(r3), .detected_slave_mask(det),
      .configured_slave_mask(cfg), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

   link_ctrl_model i_link_ctrl_model (.clk_sys(clk_sys), .arst_n(arst_n),
      .go(go), .wr(go_w), .bad_tag(bad_tag), .addr(go_a), .value(go_v),
      .stall(go_s), .status_byte1(s1), .rsp({r3, r2, r1, r0}),
      .ctrl_byte0(c0), .ctrl_byte1(c1), .req(req), .done(done),
      .ack_st(ack_st), .ack_val(ack_val), .late_st(late_st),
      .late_val(late_val));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task results;
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   task chk(input logic [31:0] seen, input logic [31:0] exp,
            input string msg);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk

   task timeout;
      n_mismatch++;
      results;
   endtask : timeout

   // one register access; valids drop as soon as each channel is taken
   task axi(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      logic ha, hw, hr;
      begin
         // one edge between accesses so no strobe is driven twice at once
         @(posedge clk_sys);
         if (w)
         begin
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
         end
         else
         begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
         end
         for (i = 0; i < 50; i++)
         begin
            @(negedge clk_sys);
            ha = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
            hw = s_axi_wvalid & s_axi_wready;
            hr = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
            rs = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge clk_sys);
            if (ha)
            begin
               s_axi_awvalid <= 1'b0;
               s_axi_arvalid <= 1'b0;
            end
            if (hw)
               s_axi_wvalid <= 1'b0;
            if (hr)
            begin
               s_axi_bready <= 1'b0;
               s_axi_rready <= 1'b0;
               break;
            end
         end
         if (i == 50)
            timeout;
      end
   endtask : axi

   task reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      axi(1'b0, a, 32'h0);
      chk(q, e, "register read data");
      chk(rs, r, "register read response");
   endtask : reg_rd

   task reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      axi(1'b1, a, d);
      chk(rs, r, "register write response");
   endtask : reg_wr

   // works out the answer that the access must get, then hands it over
   task mbx_start(input logic w, input logic [9:0] a, input logic [31:0] v,
                  input logic [3:0] s);
      e_err = 1'b1;
      e_val = ERR_NO_PARAM;
      if (w && a == PARAM_CFG_ADDR && m_lock)
         e_val = ERR_LOCKED;
      else if (w && a == PARAM_CFG_ADDR)
         e_err = 1'b0;
      else if (w && a == PARAM_DET_ADDR)
         e_val = ERR_READ_ONLY;
      else if (!w && a == PARAM_CFG_ADDR)
         e_err = 1'b0;
      else if (!w && a == PARAM_DET_ADDR)
         e_err = 1'b0;
      if (!e_err)
         e_val = w ? 32'h0 : (a == PARAM_CFG_ADDR ? m_cfg : det);
      if (!e_err && w)
         m_cfg = v;
      e_st = {ACK_TAG, e_err, 1'b1, 3'h0, w};
      go_w <= w;
      go_a <= a;
      go_v <= v;
      go_s <= s;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
   endtask : mbx_start

   task mbx_end;
      int i;
      begin
         for (i = 0; i < 300 && done !== 1'b1; i++)
            @(negedge clk_sys);
         if (i == 300)
            timeout;
         chk(ack_st & 8'hF1, e_st, "acknowledge status");
         chk(ack_val, e_val, "answer value");
         chk(late_st & 8'hF1, e_st, "held status");
         chk(late_val, e_val, "held value");
         chk(s1[7:4], 4'h0, "status after clear");
         chk(s0, STATUS0_VALUE, "status byte 0");
         chk(cfg, m_cfg, "configured mask");
         @(posedge clk_sys);
      end
   endtask : mbx_end

   task mbx(input logic w, input logic [9:0] a, input logic [31:0] v,
            input logic [3:0] s);
      mbx_start(w, a, v, s);
      mbx_end;
   endtask : mbx

   initial
   begin
      {go, go_w, bad_tag, go_a, go_v, go_s, m_lock, m_cfg} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      det = 32'h8380_024C;
      n_mismatch = 0;
      num_checks = 0;
      arst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      k = $urandom(32'hdfdd6ca5);
      @(posedge clk_sys);
      reg_rd(OFS_CTRL, {30'h0, CTRL_RESET}, RESP_OKAY);
      reg_rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
      reg_rd(OFS_CFG_MASK, 32'h0, RESP_OKAY);
      reg_rd(8'h40, 32'h0, RESP_SLVERR);
      reg_wr(8'h40, 32'h1, RESP_SLVERR);
      chk(cfg, 32'h0, "configured mask after reset");
      mbx(1'b1, PARAM_CFG_ADDR, 32'h4003_101E, 4'h0);
      reg_rd(OFS_CFG_MASK, m_cfg, RESP_OKAY);
      reg_rd(OFS_DET_MASK, det, RESP_OKAY);
      mbx(1'b0, PARAM_DET_ADDR, 32'h0, 4'h3);
      mbx(1'b0, PARAM_CFG_ADDR, 32'h0, 4'h1);
      mbx(1'b1, PARAM_DET_ADDR, 32'h1, 4'h0);
      mbx(1'b0, 10'h3FF, 32'h0, 4'h2);
      reg_wr(OFS_CTRL, 32'h3, RESP_OKAY);
      m_lock = 1'b1;
      mbx(1'b1, PARAM_CFG_ADDR, 32'hFFFF_FFFF, 4'h1);
      reg_wr(OFS_CTRL, 32'h0, RESP_OKAY);
      m_lock = 1'b0;
      // disabled mailbox must leave a pending request unanswered
      mbx_start(1'b1, PARAM_CFG_ADDR, 32'h1234_5678, 4'h0);
      repeat (10) @(posedge clk_sys);
      chk(s1, 8'h00, "answer while disabled");
      reg_wr(OFS_CTRL, 32'h1, RESP_OKAY);
      mbx_end;
      bad_tag <= 1'b1;
      mbx_start(1'b0, PARAM_DET_ADDR, 32'h0, 4'h0);
      repeat (10) @(posedge clk_sys);
      chk(s1, 8'h00, "answer to a bad tag");
      bad_tag <= 1'b0;
      mbx_end;
      reg_wr(OFS_IRQ_STATUS, 32'h7, RESP_OKAY);
      reg_wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
      chk(irq, 1'b0, "irq after clear");
      mbx(1'b0, PARAM_DET_ADDR, 32'h0, 4'h0);
      reg_rd(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
      chk(irq, 1'b1, "irq raised");
      reg_wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
      chk(irq, 1'b0, "irq masked");
      reg_wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
      reg_wr(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
      chk(irq, 1'b0, "irq cleared");
      for (k = 0; k < 12; k++)
      begin
         det <= $urandom;
         @(posedge clk_sys);
         ra = ($urandom % 3 == 0) ? PARAM_CFG_ADDR : 10'($urandom);
         mbx(1'($urandom), ra, $urandom, 4'($urandom % 8));
      end
      results;
   end
endmodule : param_mailbox_tb
